// File: alarm_pkg.sv
/*
  Shared constants and types for the measurement alarm evaluator: register
  offsets, field positions, reset values, fixed thresholds and enumerations.
  Assumes a 32-bit plain register port with byte addresses on a word grid.
*/
package alarm_pkg;

  // Widths and counts.
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 8;
  localparam int SAMPLE_W = 16;
  localparam int PCT_W    = 8;
  localparam int N_MEAS   = 2;
  localparam int N_ALM    = 4;
  localparam int N_IRQ    = 7;

  // Register offsets.
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0] OFS_FLOW_CFG  = 8'h0C;
  localparam logic [7:0] OFS_FLOW_STAT = 8'h10;
  localparam logic [7:0] OFS_ALM_BASE  = 8'h20;
  localparam logic [7:0] OFS_ALM_END   = 8'h60;
  localparam logic [3:0] SUB_CFG       = 4'h0;
  localparam logic [3:0] SUB_LEVEL     = 4'h4;
  localparam logic [3:0] SUB_HYST      = 4'h8;
  localparam logic [3:0] SUB_STAT      = 4'hC;

  // Field positions.
  localparam int CTRL_UNLATCH = 0;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_LATCH    = 2;
  localparam int CFG_FOLLOW   = 3;
  localparam int FCFG_LVL1    = 0;
  localparam int FCFG_LVL2    = 8;
  localparam int FCFG_CLS1    = 16;
  localparam int FCFG_CLS2    = 18;
  localparam int FCFG_CLSH    = 20;
  localparam int STAT_ACTIVE  = 0;
  localparam int STAT_NUM_LSB = 4;
  localparam int STAT_CHR_LSB = 8;
  localparam int STAT_VAL_LSB = 16;
  localparam int IRQ_FLOW_LSB = 4;

  // Reset values and fixed levels, flow figures in whole percent.
  localparam logic [7:0] FLOW_LVL1_RST = 8'h46;
  localparam logic [7:0] FLOW_LVL2_RST = 8'h32;
  localparam logic [7:0] FLOW_HIGH_PCT = 8'h82;
  localparam logic [7:0] CHAR_LOW      = 8'h3C;
  localparam logic [7:0] CHAR_HIGH     = 8'h3E;

  typedef enum logic [1:0] {MODE_NONE, MODE_LOW, MODE_HIGH} alarm_mode_e;
  typedef enum logic [1:0] {CLS_NONE, CLS_MAINT, CLS_FAULT} flow_class_e;

  localparam logic [1:0] CLS1_RST = 2'h1;
  localparam logic [1:0] CLS2_RST = 2'h2;
  localparam logic [1:0] CLSH_RST = 2'h0;

endpackage

// File: alarm_channel.sv
/*
  One measurement alarm: trip, hysteresis clearing, latching and capture.
  Assumes samples arrive as single-cycle valid strobes on the system clock.
*/
`timescale 1ns/1ps
module alarm_channel (
  // Clock and reset.
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Sample stream for this alarm's measurement.
  input  wire logic                           sample_valid,
  input  wire logic [alarm_pkg::SAMPLE_W-1:0] sample_value,
  // Configuration.
  input  wire logic [1:0]                     mode,
  input  wire logic                           latching,
  input  wire logic                           follow,
  input  wire logic [alarm_pkg::SAMPLE_W-1:0] level,
  input  wire logic [alarm_pkg::SAMPLE_W-1:0] hyst,
  input  wire logic                           cal_busy,
  input  wire logic                           unlatch,
  // Result.
  output logic                                active,
  output logic [alarm_pkg::SAMPLE_W-1:0]      captured
);

  typedef struct packed {
    logic                           active;
    logic [alarm_pkg::SAMPLE_W-1:0] captured;
  } state_s;

  state_s state;
  state_s next_state;

  // Trip and clear tests; the high clear needs level above hysteresis to exist.
  always_comb begin
    logic [alarm_pkg::SAMPLE_W:0] up_lim;
    logic                         trip;
    logic                         clear;
    up_lim = {1'b0, level} + {1'b0, hyst};
    trip   = 1'b0;
    clear  = 1'b0;
    next_state = state;
    unique case (mode)
      alarm_pkg::MODE_LOW: begin
        trip  = sample_value < level;
        clear = {1'b0, sample_value} > up_lim;
      end
      alarm_pkg::MODE_HIGH: begin
        trip  = sample_value > level;
        clear = (hyst <= level) && (sample_value < level - hyst);
      end
      default: begin
        trip  = 1'b0;
        clear = 1'b1;
      end
    endcase
    if (unlatch && latching) begin
      next_state.active = 1'b0;
    end
    if (sample_valid) begin
      if (!next_state.active && trip) begin
        next_state.active   = 1'b1;
        next_state.captured = sample_value;
      end else if (next_state.active && !latching && clear) begin
        next_state.active = 1'b0;
      end
    end
    // A latched alarm ignores clear; unlatch above, or mode none or calibration without follow below, releases it.
    if (mode == alarm_pkg::MODE_NONE || (cal_busy && !follow)) begin
      next_state.active = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active   = state.active;
  assign captured = state.captured;

endmodule

// File: flow_monitor.sv
/*
  Sample flow monitor: two low-flow alarms and one fixed high-flow alarm,
  each reporting a status class that is demoted during measurement work without flow calibration.
  Assumes flow arrives in whole percent with a single-cycle valid strobe.
*/
`timescale 1ns/1ps
module flow_monitor (
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Flow samples.
  input  wire logic                        flow_valid,
  input  wire logic [alarm_pkg::PCT_W-1:0] flow_pct,
  // Configuration.
  input  wire logic [alarm_pkg::PCT_W-1:0] lvl1,
  input  wire logic [alarm_pkg::PCT_W-1:0] lvl2,
  input  wire logic [1:0]                  cls1,
  input  wire logic [1:0]                  cls2,
  input  wire logic [1:0]                  clsh,
  input  wire logic                        meas_cal_busy,
  input  wire logic                        flow_cal_busy,
  // Results.
  output logic [2:0]                       hit,
  output logic [1:0]                       low1_class,
  output logic [1:0]                       low2_class,
  output logic [1:0]                       high_class
);

  typedef struct packed {
    logic [2:0] hit;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [1:0] ch;
  } state_s;

  state_s state;
  state_s next_state;

  // Class shown for a raised alarm, one step lower while demoted.
  function automatic logic [1:0] report(input logic on, input logic [1:0] cfg,
                                        input logic dem);
    logic [1:0] r;
    r = on ? cfg : 2'(alarm_pkg::CLS_NONE);
    if (dem && r == 2'(alarm_pkg::CLS_FAULT)) begin
      r = 2'(alarm_pkg::CLS_MAINT);
    end else if (dem) begin
      r = 2'(alarm_pkg::CLS_NONE);
    end
    return r;
  endfunction

  // Classes follow calibration state every cycle, comparisons only per sample.
  always_comb begin
    logic dem;
    dem = meas_cal_busy && !flow_cal_busy;
    next_state = state;
    if (flow_valid) begin
      next_state.hit[0] = flow_pct < lvl1;
      next_state.hit[1] = flow_pct < lvl2;
      next_state.hit[2] = flow_pct > alarm_pkg::FLOW_HIGH_PCT;
    end
    next_state.c1 = report(next_state.hit[0], cls1, dem);
    next_state.c2 = report(next_state.hit[1], cls2, dem);
    next_state.ch = report(next_state.hit[2], clsh, dem);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign hit        = state.hit;
  assign low1_class = state.c1;
  assign low2_class = state.c2;
  assign high_class = state.ch;

endmodule

// File: alarm_evaluator.sv
/*
  Measurement alarm evaluator top: register port, alarm configuration,
  four measurement alarms (two per measurement), flow monitor and interrupt.
  Assumes all inputs are synchronous to clk_sys and the bus master never
  raises both strobes together.
*/
// Decided for this implementation: the register offsets and the strobed register port.
// Overview of operation
// - A latching alarm stays active whatever later samples show, until unlatched.
// - A non-latching alarm drops on the first sample meeting its clear test.
// - One unlatch request releases every latched alarm at once.
// - Low alarm trips below its level; mode none never trips.
// - High alarm trips above its level.
// - Active low alarm clears only above level plus hysteresis.
// - Active high alarm clears only below level minus hysteresis.
// - Two alarms per measurement, each with own latch, level, hysteresis.
// - Alarm reads inactive when mode is none or no condition exists.
// - Active alarm reports its number, captured sample and mode.
// - Mode reports as '<' for low and '>' for high.
// - Follow off suppresses the alarm during calibration; on leaves it working.
// - Flow monitor has two low-flow alarms and one high-flow alarm.
// - Low flow 1 threshold defaults to 70 percent, class maintenance.
// - Low flow 2 threshold defaults to 50 percent, class fault.
// - High flow trips above fixed 130 percent; class defaults to none.
// - Measurement calibration demotes flow classes one step, but not while flow calibration runs at the same time.
`timescale 1ns/1ps
module alarm_evaluator (
  // Clock and reset.
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  // Register port.
  input  wire logic [alarm_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [alarm_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [alarm_pkg::DATA_W-1:0]      reg_rdata,
  // Measurement samples.
  input  wire logic                              meas_valid,
  input  wire logic                              meas_sel,
  input  wire logic [alarm_pkg::SAMPLE_W-1:0]    meas_value,
  // Flow samples.
  input  wire logic                              flow_valid,
  input  wire logic [alarm_pkg::PCT_W-1:0]       flow_pct,
  // Calibration state.
  input  wire logic                              meas_cal_busy,
  input  wire logic                              flow_cal_busy,
  // Alarm results.
  output logic      [alarm_pkg::N_ALM-1:0]       alarm_active,
  output logic      [1:0]                        flow_low1_class,
  output logic      [1:0]                        flow_low2_class,
  output logic      [1:0]                        flow_high_class,
  output logic                                   irq
);

  typedef struct packed {
    logic [alarm_pkg::N_ALM-1:0][1:0]                    mode;
    logic [alarm_pkg::N_ALM-1:0]                         latch;
    logic [alarm_pkg::N_ALM-1:0]                         follow;
    logic [alarm_pkg::N_ALM-1:0][alarm_pkg::SAMPLE_W-1:0] level;
    logic [alarm_pkg::N_ALM-1:0][alarm_pkg::SAMPLE_W-1:0] hyst;
    logic [alarm_pkg::PCT_W-1:0]                         lvl1;
    logic [alarm_pkg::PCT_W-1:0]                         lvl2;
    logic [1:0]                                          cls1;
    logic [1:0]                                          cls2;
    logic [1:0]                                          clsh;
    logic                                                unlatch;
    logic [alarm_pkg::N_IRQ-1:0]                         irq_stat;
    logic [alarm_pkg::N_IRQ-1:0]                         irq_mask;
    logic [alarm_pkg::N_ALM-1:0]                         prev_alm;
    logic [2:0]                                          prev_flow;
    logic [alarm_pkg::DATA_W-1:0]                        rdata;
    logic                                                irq;
  } state_s;

  state_s state;
  state_s next_state;

  logic [alarm_pkg::N_ALM-1:0]                         alm_on;
  logic [alarm_pkg::N_ALM-1:0][alarm_pkg::SAMPLE_W-1:0] alm_cap;
  logic [2:0]                                          flow_hit;
  logic [1:0]                                          fc1;
  logic [1:0]                                          fc2;
  logic [1:0]                                          fch;

  // Alarms 0,1 watch measurement 0 and alarms 2,3 measurement 1.
  generate
    for (genvar i = 0; i < alarm_pkg::N_ALM; i++) begin : g_alm
      alarm_channel u_alm (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .sample_valid (meas_valid && (meas_sel == 1'(i / 2))),
        .sample_value (meas_value),
        .mode         (state.mode[i]),
        .latching     (state.latch[i]),
        .follow       (state.follow[i]),
        .level        (state.level[i]),
        .hyst         (state.hyst[i]),
        .cal_busy     (meas_cal_busy),
        .unlatch      (state.unlatch),
        .active       (alm_on[i]),
        .captured     (alm_cap[i])
      );
    end
  endgenerate

  // Flow monitor with its own class demotion.
  flow_monitor u_flow (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .flow_valid    (flow_valid),
    .flow_pct      (flow_pct),
    .lvl1          (state.lvl1),
    .lvl2          (state.lvl2),
    .cls1          (state.cls1),
    .cls2          (state.cls2),
    .clsh          (state.clsh),
    .meas_cal_busy (meas_cal_busy),
    .flow_cal_busy (flow_cal_busy),
    .hit           (flow_hit),
    .low1_class    (fc1),
    .low2_class    (fc2),
    .high_class    (fch)
  );

  // Register writes, read answer, event capture and interrupt.
  always_comb begin
    logic [alarm_pkg::N_IRQ-1:0] events;
    logic [alarm_pkg::N_IRQ-1:0] w1c;
    logic [7:0]                  rel;
    int                          idx;
    events = '0;
    w1c    = '0;
    rel    = reg_addr - alarm_pkg::OFS_ALM_BASE;
    idx    = int'(rel[5:4]);
    next_state = state;
    next_state.unlatch = 1'b0;
    next_state.rdata   = '0;
    // Rising edges of each result are the interrupt events.
    events[alarm_pkg::N_ALM-1:0] = alm_on & ~state.prev_alm;
    events[alarm_pkg::IRQ_FLOW_LSB +: 3] = flow_hit & ~state.prev_flow;
    next_state.prev_alm  = alm_on;
    next_state.prev_flow = flow_hit;
    if (reg_wr) begin
      if (reg_addr == alarm_pkg::OFS_CTRL) begin
        next_state.unlatch = reg_wdata[alarm_pkg::CTRL_UNLATCH];
      end else if (reg_addr == alarm_pkg::OFS_IRQ_STAT) begin
        w1c = reg_wdata[alarm_pkg::N_IRQ-1:0];
      end else if (reg_addr == alarm_pkg::OFS_IRQ_MASK) begin
        next_state.irq_mask = reg_wdata[alarm_pkg::N_IRQ-1:0];
      end else if (reg_addr == alarm_pkg::OFS_FLOW_CFG) begin
        next_state.lvl1 = reg_wdata[alarm_pkg::FCFG_LVL1 +: 8];
        next_state.lvl2 = reg_wdata[alarm_pkg::FCFG_LVL2 +: 8];
        next_state.cls1 = reg_wdata[alarm_pkg::FCFG_CLS1 +: 2];
        next_state.cls2 = reg_wdata[alarm_pkg::FCFG_CLS2 +: 2];
        next_state.clsh = reg_wdata[alarm_pkg::FCFG_CLSH +: 2];
      end else if (reg_addr >= alarm_pkg::OFS_ALM_BASE && reg_addr < alarm_pkg::OFS_ALM_END) begin
        if (rel[3:0] == alarm_pkg::SUB_CFG) begin
          next_state.mode[idx]   = reg_wdata[alarm_pkg::CFG_MODE_LSB +: 2];
          next_state.latch[idx]  = reg_wdata[alarm_pkg::CFG_LATCH];
          next_state.follow[idx] = reg_wdata[alarm_pkg::CFG_FOLLOW];
        end else if (rel[3:0] == alarm_pkg::SUB_LEVEL) begin
          next_state.level[idx] = reg_wdata[alarm_pkg::SAMPLE_W-1:0];
        end else if (rel[3:0] == alarm_pkg::SUB_HYST) begin
          next_state.hyst[idx] = reg_wdata[alarm_pkg::SAMPLE_W-1:0];
        end
      end
    end
    // A new event in the clearing cycle keeps its bit set.
    next_state.irq_stat = (state.irq_stat & ~w1c) | events;
    next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
    if (reg_rd) begin
      if (reg_addr == alarm_pkg::OFS_IRQ_STAT) begin
        next_state.rdata[alarm_pkg::N_IRQ-1:0] = state.irq_stat;
      end else if (reg_addr == alarm_pkg::OFS_IRQ_MASK) begin
        next_state.rdata[alarm_pkg::N_IRQ-1:0] = state.irq_mask;
      end else if (reg_addr == alarm_pkg::OFS_FLOW_CFG) begin
        next_state.rdata[alarm_pkg::FCFG_LVL1 +: 8] = state.lvl1;
        next_state.rdata[alarm_pkg::FCFG_LVL2 +: 8] = state.lvl2;
        next_state.rdata[alarm_pkg::FCFG_CLS1 +: 2] = state.cls1;
        next_state.rdata[alarm_pkg::FCFG_CLS2 +: 2] = state.cls2;
        next_state.rdata[alarm_pkg::FCFG_CLSH +: 2] = state.clsh;
      end else if (reg_addr == alarm_pkg::OFS_FLOW_STAT) begin
        next_state.rdata[1:0] = fc1;
        next_state.rdata[3:2] = fc2;
        next_state.rdata[5:4] = fch;
        next_state.rdata[10:8] = flow_hit;
      end else if (reg_addr >= alarm_pkg::OFS_ALM_BASE && reg_addr < alarm_pkg::OFS_ALM_END) begin
        if (rel[3:0] == alarm_pkg::SUB_CFG) begin
          next_state.rdata[alarm_pkg::CFG_MODE_LSB +: 2] = state.mode[idx];
          next_state.rdata[alarm_pkg::CFG_LATCH]  = state.latch[idx];
          next_state.rdata[alarm_pkg::CFG_FOLLOW] = state.follow[idx];
        end else if (rel[3:0] == alarm_pkg::SUB_LEVEL) begin
          next_state.rdata[alarm_pkg::SAMPLE_W-1:0] = state.level[idx];
        end else if (rel[3:0] == alarm_pkg::SUB_HYST) begin
          next_state.rdata[alarm_pkg::SAMPLE_W-1:0] = state.hyst[idx];
        end else if (alm_on[idx]) begin
          // Status fields stay zero while the alarm is inactive.
          next_state.rdata[alarm_pkg::STAT_ACTIVE] = 1'b1;
          next_state.rdata[alarm_pkg::STAT_NUM_LSB +: 2] = 2'(idx % 2 + 1);
          next_state.rdata[alarm_pkg::STAT_CHR_LSB +: 8] =
            (state.mode[idx] == alarm_pkg::MODE_LOW) ? alarm_pkg::CHAR_LOW
                                                     : alarm_pkg::CHAR_HIGH;
          next_state.rdata[alarm_pkg::STAT_VAL_LSB +: 16] = alm_cap[idx];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= '0;
      state.lvl1 <= alarm_pkg::FLOW_LVL1_RST;
      state.lvl2 <= alarm_pkg::FLOW_LVL2_RST;
      state.cls1 <= alarm_pkg::CLS1_RST;
      state.cls2 <= alarm_pkg::CLS2_RST;
      state.clsh <= alarm_pkg::CLSH_RST;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata       = state.rdata;
  assign alarm_active    = alm_on;
  assign flow_low1_class = fc1;
  assign flow_low2_class = fc2;
  assign flow_high_class = fch;
  assign irq             = state.irq;

endmodule

// File: alarm_evaluator_properties.sv
/*
  Port-level checker for the measurement alarm evaluator, bound to its top module.
  Assumes one clock domain and a master that never raises both strobes together.
*/
`timescale 1ns/1ps
module alarm_evaluator_properties (
  // Clock and reset.
  input wire logic                         clk_sys,
  input wire logic                         rst,
  // Register port.
  input wire logic [alarm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [alarm_pkg::DATA_W-1:0] reg_rdata,
  // Samples and calibration state.
  input wire logic                         meas_valid,
  input wire logic                         flow_valid,
  input wire logic                         meas_cal_busy,
  input wire logic                         flow_cal_busy,
  // Results.
  input wire logic [alarm_pkg::N_ALM-1:0]  alarm_active,
  input wire logic [1:0]                   flow_low1_class,
  input wire logic [1:0]                   flow_low2_class,
  input wire logic [1:0]                   flow_high_class,
  input wire logic                         irq
);
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Read data stands one cycle after a read only; holes read as zero.
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
  property p_unmapped;
    reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Status view of the second alarm of the first measurement follows its flag.
  property p_stat_idle;
    reg_rd && reg_addr == 8'h3C && !alarm_active[1] |=> reg_rdata == 32'h0;
  endproperty
  a_stat_idle: assert property (p_stat_idle) else $error("idle status not zero");
  property p_stat_num;
    reg_rd && reg_addr == 8'h3C && alarm_active[1] |=> reg_rdata[5:0] == 6'h21
      && reg_rdata[15:8] inside {8'h3C, 8'h3E};
  endproperty
  a_stat_num: assert property (p_stat_num) else $error("active status wrong");
  // Measurement work without flow calibration leaves no class at fault.
  property p_demote;
    meas_cal_busy && !flow_cal_busy |=> flow_low1_class != 2'h2
      && flow_low2_class != 2'h2 && flow_high_class != 2'h2;
  endproperty
  a_demote: assert property (p_demote) else $error("flow class not demoted");
  // Results move only on a sample, a write or a calibration change.
  property p_flow_hold;
    !flow_valid && !reg_wr && !$past(reg_wr) && $stable(meas_cal_busy)
      && $stable(flow_cal_busy) |=> $stable({flow_low1_class, flow_low2_class, flow_high_class});
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow class moved alone");
  property p_alarm_hold;
    !meas_valid && !reg_wr && !$past(reg_wr) && $stable(meas_cal_busy) |=> $stable(alarm_active);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm moved alone");
  property p_no_rise;
    !meas_valid |=> (alarm_active & ~$past(alarm_active)) == 4'h0;
  endproperty
  a_no_rise: assert property (p_no_rise) else $error("alarm rose without sample");

  // Main scenarios.
  c_rise: cover property ($rose(alarm_active[1]));
  c_irq: cover property ($rose(irq));
  c_demote: cover property (meas_cal_busy && flow_low2_class == 2'h1);
endmodule

bind alarm_evaluator alarm_evaluator_properties alarm_evaluator_properties_inst (
  .clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .meas_valid, .flow_valid,
  .meas_cal_busy, .flow_cal_busy, .alarm_active, .flow_low1_class, .flow_low2_class,
  .flow_high_class, .irq
);

// File: testbench.sv
/*
  Self-checking bench for the alarm evaluator: a sample table with expected flags,
  then interrupt, status, unlatch and calibration cases.
  Assumes the property checker is bound from its own file.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic f; logic s; logic [15:0] v; logic [7:0] e;} row_s;

  // Design ports and bookkeeping.
  logic        clk_sys, rst, reg_wr, reg_rd, meas_valid, meas_sel, flow_valid, irq;
  logic        meas_cal_busy, flow_cal_busy;
  logic [7:0]  reg_addr, flow_pct;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] meas_value;
  logic [3:0]  alarm_active;
  logic [1:0]  flow_low1_class, flow_low2_class, flow_high_class;
  int          miscompares, cmp_count;
  row_s        rows[17];

  // System clock, 40 ns period.
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  alarm_evaluator alarm_evaluator_inst (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .meas_valid,
    .meas_sel, .meas_value, .flow_valid, .flow_pct, .meas_cal_busy, .flow_cal_busy,
    .alarm_active, .flow_low1_class, .flow_low2_class, .flow_high_class, .irq
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Steps past the edge so that registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One access; the strobe drops at the edge that takes it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
  endtask

  // Read data stands only in the cycle after the read, so it is sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    #1;
    chk(reg_rdata, exp);
  endtask

  // One sample pulse, measurement or flow; results land one edge later.
  task automatic smp(input logic f, input logic s, input logic [15:0] v);
    @(posedge clk_sys);
    meas_valid <= ~f;
    flow_valid <= f;
    meas_sel   <= s;
    meas_value <= v;
    flow_pct   <= v[7:0];
    @(posedge clk_sys);
    meas_valid <= 1'h0;
    flow_valid <= 1'h0;
    cyc(1);
  endtask

  task automatic cfg(input logic [7:0] b, input logic [31:0] c, input logic [31:0] l);
    bus(1'h1, b, c);
    bus(1'h1, b + 8'h04, l);
  endtask

  function automatic logic [31:0] cls();
    return {26'h0, flow_high_class, flow_low2_class, flow_low1_class};
  endfunction

  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Cuts a hung run short; the run needs well under a thousand cycles.
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  // Reset, the sample table, then the awkward cases.
  initial begin
    {rst, reg_wr, reg_rd, meas_valid, meas_sel, flow_valid} = 6'h20;
    {meas_cal_busy, flow_cal_busy, reg_addr, reg_wdata, meas_value, flow_pct} = '0;
    miscompares = 0;
    cmp_count = 0;
    rows = '{'{1'h0,1'h0,16'h0063,8'h01}, '{1'h0,1'h0,16'h0069,8'h01},
      '{1'h0,1'h0,16'h006F,8'h00}, '{1'h0,1'h0,16'h006E,8'h00}, '{1'h0,1'h0,16'h00C9,8'h02},
      '{1'h0,1'h0,16'h0096,8'h02}, '{1'h0,1'h0,16'h000A,8'h03}, '{1'h0,1'h1,16'h0033,8'h07},
      '{1'h0,1'h1,16'h0032,8'h07}, '{1'h0,1'h1,16'h0031,8'h03}, '{1'h0,1'h1,16'h0000,8'h03},
      '{1'h0,1'h0,16'h00C8,8'h02}, '{1'h1,1'h0,16'h0028,8'h09}, '{1'h1,1'h0,16'h0045,8'h01},
      '{1'h1,1'h0,16'h0046,8'h00}, '{1'h1,1'h0,16'h0031,8'h09}, '{1'h1,1'h0,16'h0032,8'h01}};
    cyc(7);
    chk({27'h0, irq, alarm_active} | cls(), 32'h0);
    @(posedge clk_sys);
    rst <= 1'h0;
    rd(8'h0C, 32'h0009_3246);
    // A zero and a normal flow calibration come before flow readings are trusted.
    repeat (2) begin
      @(posedge clk_sys);
      flow_cal_busy <= 1'h1;
      @(posedge clk_sys);
      flow_cal_busy <= 1'h0;
    end
    cfg(8'h20, 32'h0000_0001, 32'h0000_0064);
    bus(1'h1, 8'h28, 32'h0000_000A);
    cfg(8'h30, 32'h0000_0006, 32'h0000_00C8);
    bus(1'h1, 8'h38, 32'h0000_0014);
    cfg(8'h40, 32'h0000_000A, 32'h0000_0032);
    bus(1'h1, 8'h50, 32'h0000_0003);
    foreach (rows[i]) begin
      smp(rows[i].f, rows[i].s, rows[i].v);
      if (rows[i].f) begin
        chk(cls(), {24'h0, rows[i].e});
      end else begin
        chk({28'h0, alarm_active}, {24'h0, rows[i].e});
      end
    end
    // Interrupt: masked, unmasked, then cleared by writing a one.
    chk({31'h0, irq}, 32'h0);
    rd(8'h04, 32'h0000_0037);
    bus(1'h1, 8'h08, 32'h0000_0004);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, 8'h04, 32'h0000_0004);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h04, 32'h0000_0033);
    rd(8'h3C, 32'h00C9_3E21);
    rd(8'h5C, 32'h0);
    rd(8'h14, 32'h0);
    // Two latched alarms released by one unlatch write.
    bus(1'h1, 8'h20, 32'h0000_0005);
    smp(1'h0, 1'h0, 16'h000A);
    smp(1'h0, 1'h0, 16'h0096);
    chk({28'h0, alarm_active}, 32'h0000_0003);
    bus(1'h1, 8'h00, 32'h0000_0001);
    cyc(2);
    chk({28'h0, alarm_active}, 32'h0);
    rd(8'h3C, 32'h0);
    // Calibration: follow decides the alarms, flow classes are demoted.
    @(posedge clk_sys);
    meas_cal_busy <= 1'h1;
    smp(1'h0, 1'h0, 16'h000A);
    smp(1'h0, 1'h1, 16'h0033);
    chk({28'h0, alarm_active}, 32'h0000_0004);
    bus(1'h1, 8'h0C, 32'h0029_3246);
    smp(1'h1, 1'h0, 16'h0028);
    chk(cls(), 32'h0000_0004);
    @(posedge clk_sys);
    flow_cal_busy <= 1'h1;
    cyc(2);
    chk(cls(), 32'h0000_0009);
    @(posedge clk_sys);
    {meas_cal_busy, flow_cal_busy} <= 2'h0;
    smp(1'h1, 1'h0, 16'h0083);
    chk(cls(), 32'h0000_0020);
    rd(8'h10, 32'h0000_0420);
    smp(1'h1, 1'h0, 16'h0082);
    chk(cls(), 32'h0);
    // The alarm that rose during calibration has set its unmasked bit again.
    chk({31'h0, irq}, 32'h1);
    // Mid-run reset drops every result and restores the flow defaults.
    @(posedge clk_sys);
    rst <= 1'h1;
    cyc(2);
    chk({27'h0, irq, alarm_active} | cls(), 32'h0);
    @(posedge clk_sys);
    rst <= 1'h0;
    rd(8'h0C, 32'h0009_3246);
    give_verdict();
  end
endmodule
